// ==== residual_voltage_checker.sv ====
// Residual voltage checker top: APB registers, sequencer and channels
`timescale 1ns/10ps
`include "rv_params.svh"
module residual_voltage_checker
  import rv_pkg::*;
#(
  parameter int NUM_RAILS = 4,
  parameter int NUM_INPUTS = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_RAILS-1:0] rail_above_threshold,
  input wire logic [NUM_INPUTS-1:0] input_above_threshold,
  output logic [NUM_RAILS-1:0] rail_monitor_power,
  output logic [NUM_INPUTS-1:0] input_monitor_power,
  output logic [NUM_RAILS-1:0] rail_ramp_enable,
  output logic [NUM_RAILS-1:0] rail_short_flag,
  output logic [NUM_INPUTS-1:0] input_residual_flag,
  output logic boot_self_test_state
);

  localparam int NCH = NUM_RAILS + NUM_INPUTS;

  //==========================================================================
  // Register storage
  logic [31:0] rail_ctrl, next_rail_ctrl; // Enables and selects
  logic [31:0] input_ctrl, next_input_ctrl;
  logic [31:0] rail_vcode, next_rail_vcode; // rail_voltage_code fields
  logic [31:0] rail_rate, next_rail_rate; // rail_ramp_rate fields
  logic [31:0] input_level, next_input_level; // input_target_level fields
  logic [31:0] input_rate, next_input_rate; // input_ramp_rate fields
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic start_req; // One-cycle start-up request
  logic [NCH-1:0] flag_clear; // Write-one-to-clear pulses

  // Sequencer and tick
  seq_state_t seq, next_seq;
  logic armed, next_armed; // Residual monitoring armed
  logic [5:0] tick_cnt, next_tick_cnt;
  logic us_tick, next_us_tick;
  logic [NUM_RAILS-1:0] next_ramp;

  // Channel view
  chan_cfg_t cfg [NCH];
  logic [NCH-1:0] above;
  logic [NCH-1:0] flags;
  logic [NCH-1:0] powered;
  logic [NCH-1:0] active; // Monitor enable and select both set
  logic [NCH-1:0] pending; // Active channel still above threshold
  logic [NCH-1:0] boot_pending; // Selected channel above threshold at power-up

  // Bus phases
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;

  // Unmapped address test
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `RV_INPUT_RATE_OFS);
  endfunction

  //==========================================================================
  // Register next values and readback
  always_comb
  begin
    next_rail_ctrl = rail_ctrl;
    next_input_ctrl = input_ctrl;
    next_rail_vcode = rail_vcode;
    next_rail_rate = rail_rate;
    next_input_level = input_level;
    next_input_rate = input_rate;
    start_req = 1'b0;
    flag_clear = '0;
    if (wr && addr_mapped(paddr))
    begin
      case (paddr)
        `RV_RAIL_CTRL_OFS: next_rail_ctrl = pwdata;
        `RV_INPUT_CTRL_OFS: next_input_ctrl = pwdata;
        `RV_SEQ_CTRL_OFS: start_req = pwdata[`RV_START_BIT];
        `RV_STATUS_OFS: flag_clear = pwdata[NCH-1:0];
        `RV_RAIL_VCODE_OFS: next_rail_vcode = pwdata;
        `RV_RAIL_RATE_OFS: next_rail_rate = pwdata;
        `RV_INPUT_LEVEL_OFS: next_input_level = pwdata;
        `RV_INPUT_RATE_OFS: next_input_rate = pwdata;
        default: start_req = 1'b0;
      endcase
    end
    // Read data captured in setup, stable through the access phase
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup)
    begin
      next_pslverr = ~addr_mapped(paddr);
      case (paddr)
        `RV_RAIL_CTRL_OFS: next_prdata = rail_ctrl;
        `RV_INPUT_CTRL_OFS: next_prdata = input_ctrl;
        `RV_STATUS_OFS:
          next_prdata = {21'h000000, armed, 2'(seq), 2'h0, 6'(flags)};
        `RV_RAIL_VCODE_OFS: next_prdata = rail_vcode;
        `RV_RAIL_RATE_OFS: next_prdata = rail_rate;
        `RV_INPUT_LEVEL_OFS: next_prdata = input_level;
        `RV_INPUT_RATE_OFS: next_prdata = input_rate;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rail_ctrl <= `RV_RAIL_CTRL_RST;
      input_ctrl <= `RV_INPUT_CTRL_RST;
      rail_vcode <= `RV_VCODE_RST;
      rail_rate <= `RV_RATE_RST;
      input_level <= `RV_VCODE_RST;
      input_rate <= `RV_RATE_RST;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      rail_ctrl <= next_rail_ctrl;
      input_ctrl <= next_input_ctrl;
      rail_vcode <= next_rail_vcode;
      rail_rate <= next_rail_rate;
      input_level <= next_input_level;
      input_rate <= next_input_rate;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Zero-wait slave
  assign pready = 1'b1;

  //==========================================================================
  // Channel configuration: rails first, then monitor inputs
  always_comb
  begin
    for (int i = 0; i < NUM_RAILS; i++)
    begin
      cfg[i].mon_en = rail_ctrl[i];
      cfg[i].sel = rail_ctrl[`RV_SEL_POS + i];
      cfg[i].code = rail_vcode[8*i +: 8];
      cfg[i].rate = rail_rate[8*i +: 8];
      above[i] = rail_above_threshold[i];
    end
    for (int j = 0; j < NUM_INPUTS; j++)
    begin
      cfg[NUM_RAILS + j].mon_en = input_ctrl[j];
      cfg[NUM_RAILS + j].sel = input_ctrl[`RV_IN_SEL_POS + j];
      cfg[NUM_RAILS + j].code = input_level[8*j +: 8];
      cfg[NUM_RAILS + j].rate = input_rate[8*j +: 8];
      above[NUM_RAILS + j] = input_above_threshold[j];
    end
    for (int k = 0; k < NCH; k++)
    begin
      active[k] = cfg[k].mon_en & cfg[k].sel;
      pending[k] = active[k] & above[k];
      boot_pending[k] = cfg[k].sel & above[k];
    end
  end

  //==========================================================================
  // Sequencer, arming and microsecond tick
  always_comb
  begin
    next_seq = seq;
    next_armed = armed;
    // Tick drives all channel timeouts, so one divider serves them all
    next_us_tick = (tick_cnt == 6'(`RV_TICK_CYCLES - 1));
    next_tick_cnt = next_us_tick ? 6'h00 : tick_cnt + 6'h01;
    case (seq)
      SEQ_PWRUP_CHECK:
      begin
        // Hold off self-test while a selected rail keeps charge; enables
        // are still clear at power-up, so the select bits alone decide
        if (boot_pending == '0)
          next_seq = SEQ_BOOT_TEST;
      end
      SEQ_BOOT_TEST:
      begin
        if (start_req)
          next_seq = SEQ_START_CHECK;
      end
      SEQ_START_CHECK:
      begin
        // No ramp until every checked rail has decayed
        if (pending == '0)
        begin
          next_armed = 1'b0;
          next_seq = SEQ_RUNNING;
        end
      end
      SEQ_RUNNING:
        next_seq = SEQ_RUNNING;
      default:
        next_seq = SEQ_PWRUP_CHECK;
    endcase
    // Regulator enable is kept low by software for external-monitor rails
    for (int i = 0; i < NUM_RAILS; i++)
      next_ramp[i] = (next_seq == SEQ_RUNNING) & rail_ctrl[`RV_REGEN_POS + i];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq <= SEQ_PWRUP_CHECK;
      armed <= 1'b1;
      tick_cnt <= 6'h00;
      us_tick <= 1'b0;
      rail_ramp_enable <= '0;
      boot_self_test_state <= 1'b0;
    end
    else
    begin
      seq <= next_seq;
      armed <= next_armed;
      tick_cnt <= next_tick_cnt;
      us_tick <= next_us_tick;
      rail_ramp_enable <= next_ramp;
      boot_self_test_state <= (next_seq == SEQ_BOOT_TEST);
    end
  end

  //==========================================================================
  // Channels
  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    rv_channel u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .us_tick(us_tick),
      .armed(armed),
      .cfg(cfg[c]),
      .above(above[c]),
      .flag_clear(flag_clear[c]),
      .flag(flags[c]),
      .powered(powered[c])
    );
  end

  // Flags and monitor power straight from channel flops
  assign rail_short_flag = flags[NUM_RAILS-1:0];
  assign input_residual_flag = flags[NCH-1:NUM_RAILS];
  assign rail_monitor_power = powered[NUM_RAILS-1:0];
  assign input_monitor_power = powered[NCH-1:NUM_RAILS];

endmodule // residual_voltage_checker

// ==== rv_params.svh ====
// Offsets, field positions, reset values and timing counts of the residual checker
//==========================================================================
// Behaviour
// - Rail ramps only after residual below threshold
// - Selected rails checked before boot self-test
// - Checking needs monitor enable and select
// - Monitor stays powered through residual timeout
// - Still above after timeout sets rail flag
// - Timeout is target over ramp plus 100us
// - Residual monitoring armed once after power-up
// - All residual monitors disarmed before start-up
// - Monitor enable powers the rail comparators
`ifndef RV_PARAMS_SVH
`define RV_PARAMS_SVH

//==========================================================================
// Register byte offsets
`define RV_RAIL_CTRL_OFS 8'h00
`define RV_INPUT_CTRL_OFS 8'h04
`define RV_SEQ_CTRL_OFS 8'h08
`define RV_STATUS_OFS 8'h0C
`define RV_RAIL_VCODE_OFS 8'h10
`define RV_RAIL_RATE_OFS 8'h14
`define RV_INPUT_LEVEL_OFS 8'h18
`define RV_INPUT_RATE_OFS 8'h1C

//==========================================================================
// Field positions
`define RV_SEL_POS 4
`define RV_REGEN_POS 8
`define RV_IN_SEL_POS 2
`define RV_START_BIT 0
`define RV_IN_FLAG_POS 4
`define RV_STATE_POS 8
`define RV_ARMED_BIT 10

//==========================================================================
// Reset values: residual select bits default to one
`define RV_RAIL_CTRL_RST 32'h0000_00F0
`define RV_INPUT_CTRL_RST 32'h0000_000C
`define RV_VCODE_RST 32'h0000_0000
`define RV_RATE_RST 32'h0101_0101

//==========================================================================
// Timing
`define RV_CLK_PERIOD_NS 25
`define RV_TICK_NS 1000
`define RV_TICK_CYCLES ((`RV_TICK_NS + `RV_CLK_PERIOD_NS - 1) / `RV_CLK_PERIOD_NS)
`define RV_EXTRA_US 100
`define RV_EXTRA_TICKS ((`RV_EXTRA_US * 1000 + `RV_TICK_NS - 1) / `RV_TICK_NS)

`endif

// ==== rv_pkg.sv ====
// Types and the voltage-code decode shared by the residual checker
package rv_pkg;

  //==========================================================================
  // Per-channel configuration carrier
  typedef struct packed {
    logic mon_en;    // Monitor enable of rail or input
    logic sel;       // Residual check select
    logic [7:0] code; // Target voltage code
    logic [7:0] rate; // Ramp rate, 0.5 mV/us per step
  } chan_cfg_t;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_PWRUP_CHECK,
    SEQ_BOOT_TEST,
    SEQ_START_CHECK,
    SEQ_RUNNING
  } seq_state_t;

  // Channel timeout states
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_RAMP,
    CH_HOLD
  } chan_state_t;

  //==========================================================================
  // Code to target voltage in half-millivolt units
  function automatic logic [12:0] code_to_halfmv(input logic [7:0] code);
    int mv;
    mv = 0;
    if (code <= 8'h72)
      mv = 785 + 5 * (int'(code) - 'h34);
    else if (code <= 8'hAA)
      mv = 1470 + 10 * (int'(code) - 'h98);
    else
      mv = 2400 + 20 * (int'(code) - 'hD0);
    return 13'(2 * mv);
  endfunction

endpackage

// ==== rv_channel.sv ====
// One residual-check channel: timeout countdown, monitor hold and sticky flag
`timescale 1ns/10ps
`include "rv_params.svh"
module rv_channel
  import rv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic us_tick,
  input wire logic armed,
  input wire chan_cfg_t cfg,
  input wire logic above,
  input wire logic flag_clear,
  output logic flag,
  output logic powered
);

  chan_state_t state, next_state; // Timeout phase
  logic [12:0] remain, next_remain; // Voltage still to ramp, half-mV
  logic [7:0] hold, next_hold; // Extra microseconds left
  logic prev_active, next_prev_active; // Checking active last cycle
  logic next_flag;
  logic next_powered;
  logic active; // Checking enabled for this channel
  logic [7:0] rate_eff; // Zero rate treated as one step
  logic set_flag;

  //==========================================================================
  // Next-state logic
  always_comb
  begin
    active = cfg.mon_en & cfg.sel;
    rate_eff = (cfg.rate == 8'h00) ? 8'h01 : cfg.rate;
    next_state = state;
    next_remain = remain;
    next_hold = hold;
    next_prev_active = active;
    set_flag = 1'b0;
    case (state)
      CH_IDLE:
      begin
        // Monitoring switched off while checking active starts the timeout
        if (armed && prev_active && !cfg.mon_en)
        begin
          next_remain = code_to_halfmv(cfg.code);
          next_state = CH_RAMP;
        end
      end
      CH_RAMP:
      begin
        // Counting the partial last microsecond as whole rounds up
        if (us_tick)
        begin
          if (remain <= 13'(rate_eff))
          begin
            next_hold = 8'(`RV_EXTRA_TICKS);
            next_state = CH_HOLD;
          end
          else
            next_remain = remain - 13'(rate_eff);
        end
      end
      CH_HOLD:
      begin
        if (us_tick)
        begin
          if (hold == 8'h01)
          begin
            set_flag = above;
            next_state = CH_IDLE;
          end
          else
            next_hold = hold - 8'h01;
        end
      end
      default:
        next_state = CH_IDLE;
    endcase
    // Re-enabled monitor or disarmed checker abandons the timeout
    if (cfg.mon_en || !armed)
      next_state = CH_IDLE;
    // Set wins over a clear in the same cycle
    next_flag = (flag & ~flag_clear) | set_flag;
    // Comparators on while enabled or during the timeout
    next_powered = cfg.mon_en | (next_state != CH_IDLE);
  end

  //==========================================================================
  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CH_IDLE;
      remain <= 13'h0000;
      hold <= 8'h00;
      prev_active <= 1'b0;
      flag <= 1'b0;
      powered <= 1'b0;
    end
    else
    begin
      state <= next_state;
      remain <= next_remain;
      hold <= next_hold;
      prev_active <= next_prev_active;
      flag <= next_flag;
      powered <= next_powered;
    end
  end

endmodule // rv_channel

// ==== residual_voltage_checker_monitor.sv ====
// Port-level assertions of the residual voltage checker
`timescale 1ns/10ps
module residual_voltage_checker_monitor #(
  parameter int NUM_RAILS = 4,
  parameter int NUM_INPUTS = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_RAILS-1:0] rail_above_threshold,
  input wire logic [NUM_INPUTS-1:0] input_above_threshold,
  input wire logic [NUM_RAILS-1:0] rail_monitor_power,
  input wire logic [NUM_INPUTS-1:0] input_monitor_power,
  input wire logic [NUM_RAILS-1:0] rail_ramp_enable,
  input wire logic [NUM_RAILS-1:0] rail_short_flag,
  input wire logic [NUM_INPUTS-1:0] input_residual_flag,
  input wire logic boot_self_test_state
);
  //==========================================================================
  // Helper logic
  localparam int HOLD_MIN = 4000; // Hold of 100 ticks at 40 clocks
  logic [15:0] hold_cnt; // Cycles rail 0 has stayed powered
  logic [15:0] next_hold_cnt;
  logic bad_addr; // Unaligned or past the last register
  assign bad_addr = (paddr[1:0] != 2'b00) || (paddr > 8'h1C);

  // Saturating run length, so a long hold never wraps to zero
  always_comb
  begin
    next_hold_cnt = 16'h0000;
    if (rail_monitor_power[0])
      next_hold_cnt = (hold_cnt == 16'hFFFF) ? hold_cnt : hold_cnt + 16'h0001;
  end

  // Register the run length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_cnt <= 16'h0000;
    else
      hold_cnt <= next_hold_cnt;
  end

  //==========================================================================
  // Assertions
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable;
  endsequence
  sequence s_flag0_rise;
    $rose(rail_short_flag[0]);
  endsequence

  a_ready_high:
    assert property (pready) else $error("ready low");
  a_err_unmapped:
    assert property (s_access ##0 bad_addr |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped:
    assert property (s_access ##0 !bad_addr |-> !pslverr) else $error("mapped access refused");
  a_ramp_not_boot:
    assert property (|rail_ramp_enable |-> !boot_self_test_state) else $error("ramp in boot");
  a_flag_above:
    assert property (s_flag0_rise |-> $past(rail_above_threshold[0] && rail_monitor_power[0]))
    else $error("rail flag without residual");
  a_input_flag_above:
    assert property ($rose(input_residual_flag[0]) |->
      $past(input_above_threshold[0] && input_monitor_power[0])) else $error("input flag");
  a_flag_hold_time:
    assert property (s_flag0_rise |-> hold_cnt >= HOLD_MIN) else $error("flag before timeout");
  a_flag_sticky_clear:
    assert property (|($past(rail_short_flag) & ~rail_short_flag) |->
      $past(psel && penable && pwrite && paddr == 8'h0C)) else $error("flag lost");
  a_no_late_flag:
    assert property (|(rail_short_flag & ~$past(rail_short_flag)) |->
      $past(rail_ramp_enable) == '0) else $error("flag after start-up");
endmodule // residual_voltage_checker_monitor

bind residual_voltage_checker residual_voltage_checker_monitor #(
  .NUM_RAILS(NUM_RAILS), .NUM_INPUTS(NUM_INPUTS)) mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rail_above_threshold(rail_above_threshold), .input_above_threshold(input_above_threshold),
  .rail_monitor_power(rail_monitor_power), .input_monitor_power(input_monitor_power),
  .rail_ramp_enable(rail_ramp_enable), .rail_short_flag(rail_short_flag),
  .input_residual_flag(input_residual_flag), .boot_self_test_state(boot_self_test_state));

// ==== residual_voltage_checker_bench.sv ====
// Self-checking bench of the residual voltage checker
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module residual_voltage_checker_bench;
  //==========================================================================
  // Stimulus and observation
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] rail_above = 4'h0; // Rail comparators
  logic [1:0] in_above = 2'h0; // Input comparators
  wire logic [31:0] prdata;
  wire logic pready, pslverr, boot;
  wire logic [3:0] rail_pw, ramp, rail_fl;
  wire logic [1:0] in_pw, in_fl;
  int err_count = 0, cmp_count = 0;
  logic [31:0] rd; // Last read data
  logic er; // Last error response
  bit armed_exp = 1'b1; // Timeouts expected only before start-up
  logic [7:0] rst_ofs [5] = '{8'h00, 8'h04, 8'h0C, 8'h14, 8'h1C};
  logic [31:0] rst_val [5] = '{32'h0000_00F0, 32'h0000_000C, 32'h0000_0500,
    32'h0101_0101, 32'h0101_0101};

  residual_voltage_checker uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rail_above_threshold(rail_above),
    .input_above_threshold(in_above), .rail_monitor_power(rail_pw),
    .input_monitor_power(in_pw), .rail_ramp_enable(ramp), .rail_short_flag(rail_fl),
    .input_residual_flag(in_fl), .boot_self_test_state(boot));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  //==========================================================================
  // Helpers
  // Closing report, the one place the run ends
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A wait ran out of its bound
  task automatic stall();
    err_count++;
    $display("mismatch wait bound exp done got timeout");
    summarize();
  endtask

  // Target in millivolts, then ticks of the whole timeout
  function automatic int exp_ticks(input int c, input int r);
    int h;
    h = (c <= 'h72) ? 785 + 5 * (c - 'h34) : (c <= 'hAA) ? 1470 + 10 * (c - 'h98)
      : 2400 + 20 * (c - 'hD0);
    return (2 * h + r - 1) / r + 100;
  endfunction

  // Monitor power of the chosen channel
  function automatic logic pw(input bit inp, input int idx);
    return inp ? in_pw[idx] : rail_pw[idx];
  endfunction

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n >= 20)
      stall();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Enable a channel, disable it, time the hold, check and clear the flag
  task automatic run_to(input bit inp, input int idx, input bit abv, input bit sel);
    logic [7:0] c, r, ofs;
    int ex, cnt;
    logic [5:0] fexp;
    c = 8'($urandom_range(255, 52));
    r = 8'($urandom_range(255, 64));
    ex = (sel && armed_exp) ? exp_ticks(c, r) * 40 : 0;
    fexp = (abv && sel && armed_exp) ? 6'(inp ? 16 << idx : 1 << idx) : 6'h00;
    ofs = inp ? 8'h18 : 8'h10;
    apb(1'b1, ofs, 32'(c) << (8 * idx));
    apb(1'b1, ofs + 8'h04, 32'(r) << (8 * idx));
    ofs = inp ? 8'h04 : 8'h00;
    rail_above <= inp ? 4'h0 : 4'(abv) << idx;
    in_above <= inp ? 2'(abv) << idx : 2'h0;
    apb(1'b1, ofs, (32'(sel) << (idx + (inp ? 2 : 4))) | (32'h1 << idx));
    repeat (3) @(posedge pclk);
    `CHK("power on", 1'b1, pw(inp, idx))
    apb(1'b1, ofs, 32'h0);
    for (cnt = 0; pw(inp, idx) === 1'b1 && cnt < 20000; cnt++)
      @(posedge pclk);
    if (cnt >= 20000)
      stall();
    `CHK("hold", 1'b1, ex > 0 ? cnt + 80 >= ex && cnt <= ex + 80 : cnt <= 3)
    repeat (2) @(posedge pclk);
    `CHK("flags", fexp, {in_fl, rail_fl})
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("status flags", fexp, rd[5:0])
    apb(1'b1, 8'h0C, 32'h3F);
    rail_above <= 4'h0;
    in_above <= 2'h0;
    @(posedge pclk);
    `CHK("flags cleared", 6'h00, {in_fl, rail_fl})
    $display("test timeout inp %0d ch %0d done", inp, idx);
  endtask

  //==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(80));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, rst_ofs[i], 32'h0);
      `CHK("reset value", rst_val[i], rd)
    end
    `CHK("boot state", 1'b1, boot)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b0, 8'h02, 32'h0);
    `CHK("unaligned err", 1'b1, er)
    $display("test reset and map done");
    run_to(1'b0, 0, 1'b1, 1'b1);
    run_to(1'b1, 0, 1'b1, 1'b1);
    run_to(1'b0, 2, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++)
      run_to(1'b0, $urandom_range(3, 0), 1'($urandom), 1'($urandom));
    apb(1'b1, 8'h00, 32'h0000_0AF2);
    rail_above <= 4'h2;
    apb(1'b1, 8'h08, 32'h1);
    repeat (5) @(posedge pclk);
    `CHK("held ramp", 4'h0, ramp)
    `CHK("left boot", 1'b0, boot)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("start check", 3'b110, rd[10:8])
    rail_above <= 4'h0;
    for (int n = 0; ramp === 4'h0 && n < 10; n++)
      @(posedge pclk);
    `CHK("ramp", 4'hA, ramp)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("running disarmed", 3'b011, rd[10:8])
    $display("test start-up done");
    armed_exp = 1'b0;
    run_to(1'b0, 1, 1'b1, 1'b1);
    // Second reset with charge left on rail 0: self-test must wait for it
    rail_above <= 4'h1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("rearmed", 3'b100, rd[10:8])
    `CHK("boot held", 1'b0, boot)
    `CHK("power after reset", 4'h0, rail_pw)
    rail_above <= 4'h0;
    repeat (3) @(posedge pclk);
    `CHK("boot after decay", 1'b1, boot)
    $display("test second reset done");
    summarize();
  end
endmodule // residual_voltage_checker_bench
